/* File: trc_regs.vh */
// Constants for the thermistor readout configuration and control block.
// Assumes inclusion by bare name from the design files only.
`ifndef TRC_REGS_VH
`define TRC_REGS_VH
// Register byte offsets.
`define TRC_CTRL_OFS 12'h000
`define TRC_STAT_OFS 12'h004
`define TRC_IRQ_STAT_OFS 12'h008
`define TRC_IRQ_MASK_OFS 12'h00C
`define TRC_CMD_OFS 12'h010
`define TRC_NVCFG_OFS 12'h014
`define TRC_ACTCFG_OFS 12'h018
`define TRC_TYPE_OFS 12'h01C
`define TRC_RAW_OFS 12'h020
`define TRC_RESULT_OFS 12'h024
`define TRC_WDT_OFS 12'h028
// Configuration word fields: address 7:0, baud code 13:8, checksum 14, protocol 15.
`define TRC_CFG_ADDR_LSB 0
`define TRC_CFG_BAUD_LSB 8
`define TRC_CFG_CKS_BIT 14
`define TRC_CFG_PROTO_BIT 15
`define TRC_CFG_INIT_VAL 16'h0600
// Control fields.
`define TRC_CTRL_FMT_BIT 0
`define TRC_CTRL_NEWFW_BIT 1
`define TRC_CTRL_HWDT_EN_BIT 2
// Command codes written to the command register.
`define TRC_CMD_FRAME_RX 4'h1
`define TRC_CMD_RESP_DONE 4'h2
`define TRC_CMD_SET_CONFIG 4'h3
`define TRC_CMD_SET_PROTOCOL 4'h4
`define TRC_CMD_SET_TYPE 4'h5
`define TRC_CMD_RELOAD_CAL 4'h6
`define TRC_CMD_READ_CONFIG 4'h7
`define TRC_CMD_HOST_KICK 4'h8
// Interrupt status bits.
`define TRC_IRQ_UNDER 0
`define TRC_IRQ_OVER 1
`define TRC_IRQ_HWDT 2
`define TRC_IRQ_REFUSED 3
`define TRC_IRQ_MWDT 4
// Engineering and saturation codes.
`define TRC_UNDER_CODE 16'h8000
`define TRC_OVER_CODE 16'h7FFF
`define TRC_BAUD_9600 6'h06
// Module watchdog: 1 ms at 200 MHz.
`define TRC_MWDT_NS 1000000
`define TRC_CLK_NS 5
`define TRC_SAFE_RST 8'h00
`endif

/* File: trc_wdog.v */
// Module watchdog counter: restarts on a kick, pulses when it runs out.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module trc_wdog #(
  parameter LIMIT = 200000
) (
  // Clock and reset.
  input wire clk_i,
  input wire srst_i,
  // Kick and expiry.
  input wire kick_i,
  output reg expire_o
);
  reg [31:0] cnt_r;
  // Count up; a kick or an expiry starts a new period.
  always @(posedge clk_i) begin
    if (srst_i || kick_i) begin
      cnt_r <= 32'h0000_0000;
      expire_o <= 1'b0;
    end else if (cnt_r == LIMIT - 1) begin
      cnt_r <= 32'h0000_0000;
      expire_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
      expire_o <= 1'b0;
    end
  end
endmodule // trc_wdog
`default_nettype wire

/* File: trc_ctrl.v */
// Control and formatting core for an eight-channel thermistor readout, with AHB-Lite registers.
// Assumes a single AHB-Lite master, single word transfers, one clock, synchronous reset.
//
// Functional notes
// - engineering format scales within type-code limits
// - under-range gives -32768, over-range +32767
// - LED off when command frame received
// - LED on after response finished
// - override boots address 00, 9600, ASCII
// - stored config untouched, readable under override
// - baud/checksum/protocol changes need override mode
// - override strap sampled at power-on
// - host watchdog expiry forces safe outputs
// - module watchdog resets stalled logic
// - reload command restores factory calibration
// - ohm format limited to 180000/204800 ohms
// - codes 71-77 ohm limits 3200 doubling
// - protocol bit: 0 ASCII, 1 Modbus RTU
`default_nettype none
`include "trc_regs.vh"
module trc_ctrl #(
  parameter MWDT_CYC = `TRC_MWDT_NS / `TRC_CLK_NS,
  parameter [31:0] FACTORY_CAL = 32'h0001_0000 // Arbitrary default gain.
) (
  // Clock and reset.
  input wire clk_i,
  input wire srst_i,
  // AHB-Lite slave.
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  // Straps and stored configuration.
  input wire init_n_i,
  input wire [15:0] nv_cfg_i,
  // Indicators and outputs.
  output reg led_o,
  output reg [7:0] dout_o,
  output reg irq_o,
  output reg core_rst_o
);
  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Engineering low limit per type code.
  function signed [16:0] eng_lo;
    input [7:0] tc;
    begin
      case (tc)
        8'h60, 8'h69, 8'h6A, 8'h6B: eng_lo = -17'sd3000;
        8'h62: eng_lo = 17'sd0;
        8'h63, 8'h64: eng_lo = -17'sd8000;
        8'h65: eng_lo = -17'sd7000;
        8'h67, 8'h68: eng_lo = -17'sd4000;
        8'h6C: eng_lo = -17'sd1000;
        default: eng_lo = -17'sd5000;
      endcase
    end
  endfunction
  // Engineering high limit per type code.
  function signed [16:0] eng_hi;
    input [7:0] tc;
    begin
      case (tc)
        8'h60: eng_hi = 17'sd24000;
        8'h63, 8'h64, 8'h65: eng_hi = 17'sd10000;
        8'h6C: eng_hi = 17'sd20000;
        default: eng_hi = 17'sd15000;
      endcase
    end
  endfunction
  // Ohm ceiling per type code and firmware generation.
  function [17:0] ohm_max;
    input [7:0] tc;
    input newfw;
    begin
      if (!newfw) begin
        ohm_max = 18'd180000;
      end else if (tc >= 8'h71 && tc <= 8'h77) begin
        ohm_max = 18'd3200 << (tc[2:0] - 3'd1);
      end else begin
        ohm_max = 18'd204800;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  reg [31:0] ctrl_r;
  reg [7:0] type_r [0:7];
  reg [2:0] ch_sel_r;
  reg [31:0] raw_r;
  reg [15:0] result_r;
  reg [4:0] irq_stat_r;
  reg [4:0] irq_mask_r;
  reg [15:0] act_cfg_r;
  reg init_mode_r;
  reg booted_r;
  reg [31:0] cal_r;
  reg [7:0] safe_r;
  reg [7:0] dval_r;
  reg [15:0] hwdt_lim_r;
  reg [15:0] hwdt_cnt_r;
  reg hwdt_trip_r;
  reg refused_p;
  reg cfg_rd_p;
  reg [1:0] ovr_p;
  reg ph_valid_r;
  reg ph_write_r;
  reg [11:0] ph_addr_r;
  wire mwdt_expire;
  wire bus_act;
  wire wr_en;
  wire [7:0] cur_tc;
  wire [3:0] cmd;
  integer i;

  assign bus_act = hsel_i && hready_i && htrans_i[1];
  assign wr_en = ph_valid_r && ph_write_r;
  assign cmd = hwdata_i[3:0];
  assign cur_tc = type_r[ch_sel_r];

  // Module watchdog; software kicks it with every bus transfer.
  trc_wdog #(
    .LIMIT(MWDT_CYC)
  ) u_wdog (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .kick_i(bus_act),
    .expire_o(mwdt_expire)
  );

  // ---------------------------------------------------------------
  // Bus address phase capture
  // ---------------------------------------------------------------
  // Zero wait states: the data phase always completes in one cycle.
  always @(posedge clk_i) begin
    if (srst_i) begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_addr_r <= 12'h000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      ph_valid_r <= bus_act;
      ph_write_r <= hwrite_i;
      ph_addr_r <= haddr_i[11:0];
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Boot, configuration and commands
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (srst_i) begin
      booted_r <= 1'b0;
      init_mode_r <= 1'b0;
      act_cfg_r <= `TRC_CFG_INIT_VAL;
      ctrl_r <= 32'h0000_0000;
      ch_sel_r <= 3'h0;
      raw_r <= 32'h0000_0000;
      cal_r <= 32'h0000_0000;
      led_o <= 1'b1;
      safe_r <= `TRC_SAFE_RST;
      dval_r <= `TRC_SAFE_RST;
      hwdt_lim_r <= 16'hFFFF;
      refused_p <= 1'b0;
      cfg_rd_p <= 1'b0;
      irq_mask_r <= 5'h00;
      for (i = 0; i < 8; i = i + 1) begin
        type_r[i] <= 8'h60;
      end
    end else begin
      refused_p <= 1'b0;
      cfg_rd_p <= 1'b0;
      // Strap caught once after reset release, never under reset itself.
      if (!booted_r) begin
        booted_r <= 1'b1;
        init_mode_r <= !init_n_i;
        cal_r <= FACTORY_CAL;
        if (!init_n_i) begin
          act_cfg_r <= `TRC_CFG_INIT_VAL;
        end else begin
          act_cfg_r <= nv_cfg_i;
        end
      end
      if (wr_en && ph_addr_r == `TRC_CTRL_OFS) begin
        ctrl_r <= hwdata_i;
      end else if (wr_en && ph_addr_r == `TRC_IRQ_MASK_OFS) begin
        irq_mask_r <= hwdata_i[4:0];
      end else if (wr_en && ph_addr_r == `TRC_TYPE_OFS) begin
        ch_sel_r <= hwdata_i[10:8];
      end else if (wr_en && ph_addr_r == `TRC_RAW_OFS) begin
        raw_r <= hwdata_i;
      end else if (wr_en && ph_addr_r == `TRC_WDT_OFS) begin
        hwdt_lim_r <= hwdata_i[15:0];
        safe_r <= hwdata_i[23:16];
        dval_r <= hwdata_i[31:24];
      end else if (wr_en && ph_addr_r == `TRC_CMD_OFS) begin
        if (cmd == `TRC_CMD_FRAME_RX) begin
          led_o <= 1'b0;
        end else if (cmd == `TRC_CMD_RESP_DONE) begin
          led_o <= 1'b1;
        end else if (cmd == `TRC_CMD_SET_CONFIG) begin
          // Address change is always allowed; baud and checksum need override.
          act_cfg_r[7:0] <= hwdata_i[15:8];
          if (init_mode_r) begin
            act_cfg_r[14:8] <= hwdata_i[22:16];
          end else if (hwdata_i[22:16] != act_cfg_r[14:8]) begin
            refused_p <= 1'b1;
          end
        end else if (cmd == `TRC_CMD_SET_PROTOCOL) begin
          if (init_mode_r) begin
            act_cfg_r[`TRC_CFG_PROTO_BIT] <= hwdata_i[8];
          end else begin
            refused_p <= 1'b1;
          end
        end else if (cmd == `TRC_CMD_SET_TYPE) begin
          type_r[hwdata_i[10:8]] <= hwdata_i[23:16];
        end else if (cmd == `TRC_CMD_RELOAD_CAL) begin
          cal_r <= FACTORY_CAL;
        end else if (cmd == `TRC_CMD_READ_CONFIG) begin
          cfg_rd_p <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Host watchdog and safe outputs
  // ---------------------------------------------------------------
  // Counts clocks; the limit register is in cycles so a bench can shorten it.
  always @(posedge clk_i) begin
    if (srst_i) begin
      hwdt_cnt_r <= 16'h0000;
      hwdt_trip_r <= 1'b0;
      dout_o <= `TRC_SAFE_RST;
    end else begin
      if (wr_en && ph_addr_r == `TRC_CMD_OFS && cmd == `TRC_CMD_HOST_KICK) begin
        hwdt_cnt_r <= 16'h0000;
        hwdt_trip_r <= 1'b0;
      end else if (ctrl_r[`TRC_CTRL_HWDT_EN_BIT] && !hwdt_trip_r) begin
        if (hwdt_cnt_r >= hwdt_lim_r) begin
          hwdt_trip_r <= 1'b1;
        end else begin
          hwdt_cnt_r <= hwdt_cnt_r + 16'h0001;
        end
      end
      dout_o <= hwdt_trip_r ? safe_r : dval_r;
    end
  end

  // ---------------------------------------------------------------
  // Formatting and saturation
  // ---------------------------------------------------------------
  // Raw sample is signed engineering units, or unsigned ohms in ohm format.
  always @(posedge clk_i) begin
    if (srst_i) begin
      result_r <= 16'h0000;
      ovr_p <= 2'b00;
    end else if (ctrl_r[`TRC_CTRL_FMT_BIT]) begin
      // Ohm format reports tenths-free ohms scaled down by 4 to fit 16 bits.
      if (raw_r[17:0] > ohm_max(cur_tc, ctrl_r[`TRC_CTRL_NEWFW_BIT]) || |raw_r[31:18]) begin
        result_r <= `TRC_OVER_CODE;
        ovr_p <= 2'b10;
      end else begin
        result_r <= raw_r[17:2];
        ovr_p <= 2'b00;
      end
    end else if ($signed(raw_r) < eng_lo(cur_tc)) begin
      result_r <= `TRC_UNDER_CODE;
      ovr_p <= 2'b01;
    end else if ($signed(raw_r) > eng_hi(cur_tc)) begin
      result_r <= `TRC_OVER_CODE;
      ovr_p <= 2'b10;
    end else begin
      result_r <= raw_r[15:0];
      ovr_p <= 2'b00;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts and module reset
  // ---------------------------------------------------------------
  // Set wins over a write-one clear in the same cycle.
  always @(posedge clk_i) begin
    if (srst_i) begin
      irq_stat_r <= 5'h00;
      irq_o <= 1'b0;
      core_rst_o <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_en && ph_addr_r == `TRC_IRQ_STAT_OFS) ?
                     hwdata_i[4:0] : 5'h00)) |
                    {mwdt_expire, refused_p, hwdt_trip_r, ovr_p[1], ovr_p[0]};
      irq_o <= |(irq_stat_r & irq_mask_r);
      core_rst_o <= mwdt_expire;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Stored configuration reads back unchanged even under override.
  always @(posedge clk_i) begin
    if (srst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (bus_act && !hwrite_i) begin
      if (haddr_i[11:0] == `TRC_CTRL_OFS) begin
        hrdata_o <= ctrl_r;
      end else if (haddr_i[11:0] == `TRC_STAT_OFS) begin
        hrdata_o <= {27'h0, core_rst_o, hwdt_trip_r, cfg_rd_p, led_o, init_mode_r};
      end else if (haddr_i[11:0] == `TRC_IRQ_STAT_OFS) begin
        hrdata_o <= {27'h0, irq_stat_r};
      end else if (haddr_i[11:0] == `TRC_IRQ_MASK_OFS) begin
        hrdata_o <= {27'h0, irq_mask_r};
      end else if (haddr_i[11:0] == `TRC_NVCFG_OFS) begin
        hrdata_o <= {16'h0, nv_cfg_i};
      end else if (haddr_i[11:0] == `TRC_ACTCFG_OFS) begin
        hrdata_o <= {16'h0, act_cfg_r};
      end else if (haddr_i[11:0] == `TRC_TYPE_OFS) begin
        hrdata_o <= {21'h0, ch_sel_r, cur_tc};
      end else if (haddr_i[11:0] == `TRC_RAW_OFS) begin
        hrdata_o <= cal_r;
      end else if (haddr_i[11:0] == `TRC_RESULT_OFS) begin
        hrdata_o <= {16'h0, result_r};
      end else if (haddr_i[11:0] == `TRC_WDT_OFS) begin
        hrdata_o <= {dval_r, safe_r, hwdt_lim_r};
      end else begin
        hrdata_o <= 32'h0000_0000;
      end
    end
  end
endmodule // trc_ctrl
`default_nettype wire

/* File: trc_strap_model.sv */
// Far-side model: installer strap and stored configuration.
// Assumes the bench picks the mode before each reset.
`default_nettype none
module trc_strap_model (
  // Installer choice.
  input wire logic override_i,
  input wire logic [15:0] stored_i,
  // Pins seen by the block.
  output logic init_n_o,
  output logic [15:0] nv_cfg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Override is chosen by tying the strap to ground.
  assign init_n_o = !override_i;
  // Stored settings stand still; the block only samples them.
  assign nv_cfg_o = stored_i;
endmodule // trc_strap_model
`default_nettype wire

/* File: trc_ctrl_checker.sv */
// Port checker for trc_ctrl, bound to each instance.
// Assumes one clock and the zero-wait bus timing of the block.
`default_nettype none
module trc_ctrl_checker (
  // Clock, reset and bus.
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // Indicators and outputs.
  input wire logic led_o,
  input wire logic [7:0] dout_o,
  input wire logic irq_o,
  input wire logic core_rst_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // Helper logic
  // ----------------
  logic take;
  logic cmd_q;
  // Address phase accepted at this edge.
  assign take = hsel_i && hready_i && htrans_i[1];
  // Marks the data phase of a command write, where the code is on the bus.
  always_ff @(posedge clk_i) begin
    cmd_q <= !srst_i && take && hwrite_i && haddr_i[11:0] == 12'h010;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  chk_ready_high: assert property (hreadyout_o)
    else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp_o)
    else $error("hresp not okay");
  chk_led_off: assert property (cmd_q && hwdata_i[3:0] == 4'h1 |-> ##[1:2] !led_o)
    else $error("led still on after frame");
  chk_led_on: assert property (cmd_q && hwdata_i[3:0] == 4'h2 |-> ##[1:2] led_o)
    else $error("led still off after response");
  chk_boot_led: assert property ($fell(srst_i) |-> led_o && !irq_o)
    else $error("led or irq wrong at reset");
  chk_boot_out: assert property ($fell(srst_i) |-> dout_o == 8'h00 && !core_rst_o)
    else $error("outputs wrong at reset");
  chk_rst_pulse: assert property (core_rst_o |=> !core_rst_o)
    else $error("core reset longer than a pulse");
  // Core reset cycles are excused too, although core_rst_o never changes the read data.
  chk_rdata_hold: assert property (!(take && !hwrite_i) && !core_rst_o |=> $stable(hrdata_o))
    else $error("read data moved without a read");
endmodule // trc_ctrl_checker
bind trc_ctrl trc_ctrl_checker trc_ctrl_checker_inst (.clk_i(clk_i), .srst_i(srst_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .led_o(led_o), .dout_o(dout_o),
  .irq_o(irq_o), .core_rst_o(core_rst_o));
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for trc_ctrl through its AHB-Lite registers.
// Assumes the strap model and the bound checker are compiled first.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, srst_i = 1, hsel = 0, hwrite = 0, ovr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic hready, hresp, init_n, led, irq, crst;
  logic [7:0] dout;
  logic [15:0] nvc = 0, nv_cfg;
  int n_errors = 0, tests_run = 0, i;
  initial forever #2.5 clk_i = ~clk_i;
  trc_strap_model trc_strap_model_inst (.override_i(ovr), .stored_i(nvc), .init_n_o(init_n),
    .nv_cfg_o(nv_cfg));
  // The module watchdog is shortened so its expiry fits the run.
  trc_ctrl #(.MWDT_CYC(50), .FACTORY_CAL(32'h0002_1234)) trc_ctrl_inst (.clk_i(clk_i),
    .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .init_n_i(init_n), .nv_cfg_i(nv_cfg),
    .led_o(led), .dout_o(dout), .irq_o(irq), .core_rst_o(crst));
  // ----------------
  // Bus and compare tasks
  // ----------------
  task automatic finish_test;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waits for hready at a rising edge; a hung slave ends the run.
  task automatic wait_rdy;
    int k = 0;
    @(posedge clk_i);
    while (hready !== 1'b1) begin
      if (++k > 50) begin
        n_errors++;
        finish_test;
      end
      @(posedge clk_i);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hsize <= 3'b010;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [31:0] a, e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // The result lags a raw write by one cycle, hence the idle edge.
  task automatic res(input logic [31:0] raw, input logic [15:0] e);
    wr(32'h20, raw);
    @(posedge clk_i);
    xfer(1'b0, 32'h24, 32'h0);
    chk("result", {16'h0, e}, {16'h0, rd[15:0]});
  endtask
  task automatic boot(input logic o, input logic [15:0] c);
    ovr <= o;
    nvc <= c;
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    // The strap and stored settings land at the first edge, so leave it idle.
    @(posedge clk_i);
  endtask
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    boot(1'b1, 16'hA5C3);
    rdc("actcfg", 32'h18, 32'h0600);
    wr(32'h10, 32'h0000_0007);
    rdc("stat", 32'h04, 32'h07);
    wr(32'h10, 32'h0007_0003);
    wr(32'h10, 32'h0000_0104);
    rdc("actcfg", 32'h18, 32'h8700);
    rdc("nvcfg", 32'h14, 32'hA5C3);
    boot(1'b0, 16'h4A12);
    rdc("actcfg", 32'h18, 32'h4A12);
    wr(32'h10, 32'h0007_3403);
    wr(32'h10, 32'h0000_0104);
    rdc("actcfg", 32'h18, 32'h4A34);
    rdc("irq_stat", 32'h08, 32'h08);
    wr(32'h0C, 32'h08);
    repeat (2) @(posedge clk_i);
    chk("irq", 32'h1, {31'h0, irq});
    wr(32'h08, 32'h08);
    repeat (2) @(posedge clk_i);
    chk("irq", 32'h0, {31'h0, irq});
    wr(32'h10, 32'h1);
    @(posedge clk_i);
    chk("led", 32'h0, {31'h0, led});
    wr(32'h10, 32'h2);
    @(posedge clk_i);
    chk("led", 32'h1, {31'h0, led});
    wr(32'h00, 32'h0);
    res(32'hFFFF_F447, 16'h8000);
    res(32'h0000_5DC1, 16'h7FFF);
    res(32'h0000_5DC0, 16'h5DC0);
    wr(32'h10, 32'h0070_0005);
    res(32'h0000_3A99, 16'h7FFF);
    res(32'hFFFF_EC78, 16'hEC78);
    res(32'hFFFF_EC77, 16'h8000);
    rdc("irq_stat", 32'h08, 32'h03);
    wr(32'h08, 32'h03);
    wr(32'h00, 32'h1);
    wr(32'h10, 32'h0060_0005);
    res(32'h0002_BF20, 16'hAFC8);
    res(32'h0002_BF21, 16'h7FFF);
    wr(32'h00, 32'h3);
    res(32'h0003_2001, 16'h7FFF);
    for (i = 0; i < 7; i++) begin
      wr(32'h10, {8'h00, 8'h71 + 8'(i), 16'h0005});
      res(32'hC80 << i, 16'((32'hC80 << i) >> 2));
      res((32'hC80 << i) + 32'h1, 16'h7FFF);
    end
    wr(32'h10, 32'h6);
    rdc("cal", 32'h20, 32'h0002_1234);
    wr(32'h28, 32'h5AC3_0014);
    // The output value lands at the data edge and reaches the pins one edge later.
    repeat (2) @(posedge clk_i);
    chk("dout", 32'h5A, {24'h0, dout});
    wr(32'h00, 32'h4);
    repeat (30) @(posedge clk_i);
    chk("dout", 32'hC3, {24'h0, dout});
    wr(32'h10, 32'h0000_0008);
    repeat (2) @(posedge clk_i);
    chk("dout", 32'h5A, {24'h0, dout});
    i = 0;
    while (crst !== 1'b1 && i < 100) begin
      @(posedge clk_i);
      i++;
    end
    chk("core_rst", 32'h1, {31'h0, crst});
    finish_test;
  end
endmodule // testbench
`default_nettype wire
